// ===== shared/supervisor_defs.vh
/*
  Timing constants and field positions for the link fail supervisor.
  Assumes a 100 MHz core clock; included by bare name from core files.
*/
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define CLK_PER_US         (1000 / `CLK_PERIOD_NS)
`define CLK_PER_MS         (1000000 / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Times as printed
// ----------------------------------------------------------------------
`define WD_SHORT_MS        32
`define WD_LONG_MS         128
`define IN_DGL_US          200
`define RST_DGL_US         10
`define CLK_DGL_NS         2000
`define CLK_LOW_HZ         100

// ----------------------------------------------------------------------
// Derived cycle counts
// ----------------------------------------------------------------------
`define WD_SHORT_CYC       (`WD_SHORT_MS * `CLK_PER_MS)
`define WD_LONG_CYC        (`WD_LONG_MS * `CLK_PER_MS)
`define IN_DGL_CYC         (`IN_DGL_US * `CLK_PER_US)
`define RST_DGL_CYC        (`RST_DGL_US * `CLK_PER_US)
`define CLK_DGL_CYC        (`CLK_DGL_NS / `CLK_PERIOD_NS)
`define CLK_LOW_CYC        (1000000000 / (`CLK_LOW_HZ * `CLK_PERIOD_NS))

// ----------------------------------------------------------------------
// Frame layout and status bits
// ----------------------------------------------------------------------
`define FRAME_BITS         16
`define TOGGLE_BIT_POS     15
`define CH6_BIT_POS        5
`define STAT7_SPI_FAILURE_FLAG_BIT     0
`define STAT7_FAIL_IN_BIT  1

`endif

// ===== core/sync2.v
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/100ps
module sync2 #(
  parameter INIT = 1'b0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire srst_i,
  input  wire ce_i,
  // Data
  input  wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else if (ce_i) begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // sync2

// ===== core/deglitch.v
/*
  Counter deglitcher: output follows input once the input has held a
  new level for RISE_CYC (rising) or FALL_CYC (falling) cycles.
  Assumes a synchronised input.
*/
`timescale 1ns/100ps
module deglitch #(
  parameter integer CNT_W    = 16,
  parameter integer RISE_CYC = 20000,
  parameter integer FALL_CYC = 20000,
  parameter         INIT     = 1'b0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire srst_i,
  input  wire ce_i,
  // Data
  input  wire d_i,
  output wire q_o
);
  reg             q_reg;
  reg [CNT_W-1:0] cnt_reg;
  wire [CNT_W-1:0] lim = q_reg ? FALL_CYC[CNT_W-1:0] : RISE_CYC[CNT_W-1:0];

  always @(posedge clk_i) begin
    if (srst_i) begin
      q_reg   <= INIT;
      cnt_reg <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      if (d_i == q_reg) begin
        cnt_reg <= {CNT_W{1'b0}};
      end else if (cnt_reg + 1'b1 >= lim) begin
        q_reg   <= d_i;
        cnt_reg <= {CNT_W{1'b0}};
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign q_o = q_reg;
endmodule // deglitch

// ===== core/spi_link_fail_supervisor.v
/*
  Link fail supervisor: watches the serial link for toggle, timeout and
  length faults, filters the fail, direct, reset and clock inputs,
  detects a slow clock and steers channels and the external switch.
  Assumes serial pins and clock pin are asynchronous; the serial clock
  is sampled by clk_i, so it must be far slower than clk_i.
*/
`timescale 1ns/100ps
`include "supervisor_defs.vh"

// Operation
// RULE1 - Any link fault forces fail mode
// RULE2 - Untoggled watchdog bit is a link fault
// RULE3 - No valid frame within period: fault
// RULE4 - Chip-select bit count not multiple of sixteen
// RULE5 - Failure flag shown in status seven
// RULE6 - Flag held in fail, cleared leaving fail
// RULE7 - Stuck data or lost supply: toggle fault
// RULE8 - Fail and direct inputs deglitched symmetrically
// RULE9 - Filtered fail input requests fail mode
// RULE10 - Filtered direct input drives its channel
// RULE11 - Reset input deglitched on falling edge only
// RULE12 - Clock deglitched; too fast means failure
// RULE13 - Slow clock flagged after reset release
// RULE14 - Failed clock: outputs follow channel control
// RULE15 - Clock fail latched until gone and read
// RULE16 - External switch follows channel six, normal only
// RULE17 - External switch off in sleep, fail
// RULE18 - Fail mode: channels follow direct inputs
// RULE19 - Fail input level readable in status seven
// RULE20 - Filters and watchdog are timebase counters
module spi_link_fail_supervisor #(
  parameter integer CH_N        = 4,
  parameter integer WD_W        = 24,
  parameter integer WD_SHORT    = `WD_SHORT_CYC,
  parameter integer WD_LONG     = `WD_LONG_CYC,
  parameter integer CLK_LOW_CYC = `CLK_LOW_CYC
) (
  // Clock, reset, enable
  input  wire            clk_i,
  input  wire            srst_i,
  input  wire            ce_i,
  // Serial link pins
  input  wire            sclk_i,
  input  wire            cs_n_i,
  input  wire            sdi_i,
  // Direct pins
  input  wire            fail_mode_i,
  input  wire [CH_N-1:0] direct_channel_inputs_i,
  input  wire            reset_input_n_i,
  input  wire            ext_clock_i,
  // Configuration and status
  input  wire            watchdog_period_select_i,
  input  wire            sleep_i,
  input  wire [CH_N-1:0] channel_control_signal_i,
  input  wire [CH_N-1:0] pwm_channel_i,
  input  wire            quick_status1_read_i,
  output wire [15:0]     device_status7_o,
  output wire            spi_failure_flag_o,
  output wire            fail_mode_o,
  output wire            clock_fail_o,
  output wire [CH_N-1:0] channel_out_o,
  output wire            external_switch_control_o,
  // Received frame
  output wire [15:0]     frame_data_o,
  output wire            frame_valid_o
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire sclk_s;
  wire cs_n_s;
  wire sdi_s;
  wire fail_s;
  wire rstn_s;
  wire eclk_s;
  wire [CH_N-1:0] din_s;

  sync2 u_sync_sclk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .d_i(sclk_i),
                     .q_o(sclk_s));
  // Idle-high reset, so leaving reset is never taken as a frame end
  sync2 #(.INIT(1'b1)) u_sync_cs (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
                                  .d_i(cs_n_i), .q_o(cs_n_s));
  sync2 u_sync_sdi  (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .d_i(sdi_i),
                     .q_o(sdi_s));
  sync2 u_sync_fail (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
                     .d_i(fail_mode_i), .q_o(fail_s));
  sync2 u_sync_rstn (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
                     .d_i(reset_input_n_i), .q_o(rstn_s));
  sync2 u_sync_eclk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
                     .d_i(ext_clock_i), .q_o(eclk_s));

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi = gi + 1) begin : g_din
      sync2 u_sync_din (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
                        .d_i(direct_channel_inputs_i[gi]), .q_o(din_s[gi]));
    end
  endgenerate

  // --------------------------------------------------------------------
  // Deglitch filters
  // --------------------------------------------------------------------
  wire filtered_fail_request;
  wire [CH_N-1:0] filtered_direct_input;
  wire rstn_f;
  wire eclk_f;

  deglitch #(.CNT_W(16), .RISE_CYC(`IN_DGL_CYC), .FALL_CYC(`IN_DGL_CYC),
             .INIT(1'b0)) u_dgl_fail ( // RULE8 RULE9 RULE20
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .d_i(fail_s), .q_o(filtered_fail_request));

  generate
    for (gi = 0; gi < CH_N; gi = gi + 1) begin : g_dgl
      deglitch #(.CNT_W(16), .RISE_CYC(`IN_DGL_CYC), .FALL_CYC(`IN_DGL_CYC),
                 .INIT(1'b0)) u_dgl_din ( // RULE8 RULE10
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .d_i(din_s[gi]), .q_o(filtered_direct_input[gi]));
    end
  endgenerate

  // Rising edge passes after one cycle; falling edge waits out the filter
  deglitch #(.CNT_W(16), .RISE_CYC(1), .FALL_CYC(`RST_DGL_CYC),
             .INIT(1'b0)) u_dgl_rst ( // RULE11
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .d_i(rstn_s), .q_o(rstn_f));

  // Too-fast clock never settles here, so it looks like a stopped clock
  deglitch #(.CNT_W(16), .RISE_CYC(`CLK_DGL_CYC), .FALL_CYC(`CLK_DGL_CYC),
             .INIT(1'b0)) u_dgl_clk ( // RULE12
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .d_i(eclk_s), .q_o(eclk_f));

  // --------------------------------------------------------------------
  // Serial frame receiver
  // --------------------------------------------------------------------
  reg        sclk_d_reg;
  reg        cs_n_d_reg;
  reg [15:0] shift_reg;
  reg [3:0]  bit_cnt_reg;
  reg        any_bits_reg;
  reg        last_toggle_reg;
  reg        toggle_seen_reg;
  reg [15:0] frame_reg;
  reg        frame_valid_reg;
  reg        frame_event_reg;
  reg        frame_ok_reg;

  wire sclk_rise  = sclk_s & ~sclk_d_reg;
  wire cs_rise    = cs_n_s & ~cs_n_d_reg;
  wire len_ok     = (bit_cnt_reg == 4'h0) & any_bits_reg; // RULE4
  // Stuck data or dead supply keeps the bit equal across frames
  wire toggle_ok  = ~toggle_seen_reg |
                    (shift_reg[`TOGGLE_BIT_POS] != last_toggle_reg); // RULE2 RULE7

  always @(posedge clk_i) begin
    if (srst_i) begin
      sclk_d_reg      <= 1'b0;
      cs_n_d_reg      <= 1'b1;
      shift_reg       <= 16'h0000;
      bit_cnt_reg     <= 4'h0;
      any_bits_reg    <= 1'b0;
      last_toggle_reg <= 1'b0;
      toggle_seen_reg <= 1'b0;
      frame_reg       <= 16'h0000;
      frame_valid_reg <= 1'b0;
      frame_event_reg <= 1'b0;
      frame_ok_reg    <= 1'b0;
    end else if (ce_i) begin
      sclk_d_reg      <= sclk_s;
      cs_n_d_reg      <= cs_n_s;
      frame_valid_reg <= 1'b0;
      frame_event_reg <= 1'b0;
      if (!cs_n_s && sclk_rise) begin
        shift_reg    <= {shift_reg[14:0], sdi_s};
        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
        any_bits_reg <= 1'b1;
      end
      if (cs_rise) begin
        frame_event_reg <= 1'b1;
        frame_ok_reg    <= len_ok & toggle_ok;
        bit_cnt_reg     <= 4'h0;
        any_bits_reg    <= 1'b0;
        if (len_ok) begin
          last_toggle_reg <= shift_reg[`TOGGLE_BIT_POS];
          toggle_seen_reg <= 1'b1;
          frame_valid_reg <= toggle_ok;
          // Rejected frames never reach the switch setting
          if (toggle_ok) begin
            frame_reg <= shift_reg;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Watchdog timer
  // --------------------------------------------------------------------
  reg  [WD_W-1:0] wd_cnt_reg;
  wire [WD_W-1:0] wd_lim = watchdog_period_select_i ? WD_LONG[WD_W-1:0]
                                                    : WD_SHORT[WD_W-1:0];
  wire wd_expire = (wd_cnt_reg >= wd_lim - 1'b1); // RULE3

  always @(posedge clk_i) begin
    if (srst_i) begin
      wd_cnt_reg <= {WD_W{1'b0}};
    end else if (ce_i) begin
      if (frame_valid_reg || wd_expire) begin
        wd_cnt_reg <= {WD_W{1'b0}}; // RULE20
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode state machine
  // --------------------------------------------------------------------
  localparam [1:0] ST_NORMAL = 2'b01;
  localparam [1:0] ST_FAIL   = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg       spi_failure_flag_reg;

  wire link_fault = (frame_event_reg & ~frame_ok_reg) | wd_expire;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        if (link_fault || filtered_fail_request) begin
          state_next = ST_FAIL; // RULE1 RULE9
        end
      end
      ST_FAIL: begin
        // Leave only on a good frame with the fail input released
        if (frame_valid_reg && !filtered_fail_request) begin
          state_next = ST_NORMAL;
        end
      end
      default: begin
        state_next = ST_FAIL;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg            <= ST_NORMAL;
      spi_failure_flag_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (state_reg == ST_NORMAL && link_fault) begin
        spi_failure_flag_reg <= 1'b1; // RULE5
      end else if (state_reg == ST_FAIL && state_next == ST_NORMAL) begin
        spi_failure_flag_reg <= 1'b0; // RULE6
      end
    end
  end

  wire in_fail = (state_reg == ST_FAIL);

  // --------------------------------------------------------------------
  // Clock failure monitor
  // --------------------------------------------------------------------
  reg        eclk_d_reg;
  reg        rstn_d_reg;
  reg        mon_en_reg;
  reg [23:0] period_cnt_reg;
  reg        clk_bad_reg;
  reg        clock_fail_reg;

  wire eclk_rise = eclk_f & ~eclk_d_reg;
  wire rst_rise  = rstn_f & ~rstn_d_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      eclk_d_reg     <= 1'b0;
      rstn_d_reg     <= 1'b0;
      mon_en_reg     <= 1'b0;
      period_cnt_reg <= 24'h000000;
      clk_bad_reg    <= 1'b0;
      clock_fail_reg <= 1'b0;
    end else if (ce_i) begin
      eclk_d_reg <= eclk_f;
      rstn_d_reg <= rstn_f;
      if (!rstn_f) begin
        mon_en_reg <= 1'b0;
      end else if (rst_rise) begin
        mon_en_reg <= 1'b1; // RULE13
      end
      if (rst_rise || eclk_rise) begin
        period_cnt_reg <= 24'h000000;
        clk_bad_reg    <= 1'b0;
      end else if (mon_en_reg) begin
        if (period_cnt_reg >= CLK_LOW_CYC[23:0] - 24'h000001) begin
          clk_bad_reg <= 1'b1; // RULE13
        end else begin
          period_cnt_reg <= period_cnt_reg + 24'h000001;
        end
      end
      // Set wins over a read in the same cycle
      if (mon_en_reg && clk_bad_reg) begin
        clock_fail_reg <= 1'b1;
      end else if (quick_status1_read_i) begin
        clock_fail_reg <= 1'b0; // RULE15
      end
    end
  end

  // --------------------------------------------------------------------
  // Output steering
  // --------------------------------------------------------------------
  reg [CH_N-1:0] channel_out_reg;
  reg            ext_sw_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      channel_out_reg <= {CH_N{1'b0}};
      ext_sw_reg      <= 1'b0;
    end else if (ce_i) begin
      if (in_fail) begin
        channel_out_reg <= filtered_direct_input; // RULE18 RULE10
      end else if (clk_bad_reg) begin
        channel_out_reg <= channel_control_signal_i; // RULE14
      end else begin
        channel_out_reg <= pwm_channel_i; // RULE14
      end
      if (in_fail || sleep_i) begin
        ext_sw_reg <= 1'b0; // RULE17
      end else begin
        // Last accepted setting returns after fail or sleep
        ext_sw_reg <= frame_reg[`CH6_BIT_POS]; // RULE16
      end
    end
  end

  assign channel_out_o             = channel_out_reg;
  assign external_switch_control_o = ext_sw_reg;
  assign spi_failure_flag_o        = spi_failure_flag_reg;
  assign fail_mode_o               = in_fail;
  assign clock_fail_o              = clock_fail_reg;
  assign frame_data_o              = frame_reg;
  assign frame_valid_o             = frame_valid_reg;
  assign device_status7_o          = {14'h0000, fail_s,
                                      spi_failure_flag_reg}; // RULE5 RULE19

endmodule // spi_link_fail_supervisor

// ===== tb/supervisor_assertions.sv
/*
  Checker for the link fail supervisor, bound to its top ports.
  Assumes one clk_i domain and the synchronous srst_i.
*/
`timescale 1ns/100ps
module supervisor_checker #(
  parameter integer CH_N     = 4,
  parameter integer WD_SHORT = 2000,
  parameter integer WD_LONG  = 8000
) (
  // Clock and reset
  input wire            clk_i,
  input wire            srst_i,
  // Inputs
  input wire            fail_mode_i,
  input wire            sleep_i,
  input wire            watchdog_period_select_i,
  input wire [CH_N-1:0] pwm_channel_i,
  input wire            quick_status1_read_i,
  // Outputs
  input wire [15:0]     device_status7_o,
  input wire            spi_failure_flag_o,
  input wire            fail_mode_o,
  input wire            clock_fail_o,
  input wire [CH_N-1:0] channel_out_o,
  input wire            external_switch_control_o,
  input wire [15:0]     frame_data_o,
  input wire            frame_valid_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  reg        seen_reg;
  reg [23:0] idle_reg;
  // Saturates so a dead link never wraps back to a quiet count
  always @(posedge clk_i) begin
    if (srst_i || frame_valid_o) begin
      idle_reg <= 24'h0;
    end else if (idle_reg != 24'hffffff) begin
      idle_reg <= idle_reg + 24'h1;
    end
    if (srst_i) begin
      seen_reg <= 1'b0;
    end else if (frame_valid_o) begin
      seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_frame_taken;
    frame_valid_o && !fail_mode_o && !sleep_i;
  endsequence
  sequence s_normal_run;
    (!fail_mode_o && !clock_fail_o) [*3];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_status_flag_copy: assert property (device_status7_o ==
    {14'h0, device_status7_o[1], spi_failure_flag_o}) else $error("status7 flag bad");
  a_status_pin_level: assert property (device_status7_o[1] == $past(fail_mode_i, 2))
    else $error("status7 pin bit bad");
  a_switch_off_fail: assert property ((fail_mode_o && $past(fail_mode_o)) ||
    $past(sleep_i) |-> !external_switch_control_o) else $error("switch on in fail");
  a_flag_held_fail: assert property ($past(spi_failure_flag_o) && fail_mode_o |->
    spi_failure_flag_o) else $error("flag lost in fail");
  a_flag_clear_exit: assert property ($fell(fail_mode_o) |-> !spi_failure_flag_o)
    else $error("flag kept after exit");
  a_flag_enters_fail: assert property ($rose(spi_failure_flag_o) |-> ##[0:1] fail_mode_o)
    else $error("fault without fail");
  a_toggle_inverted: assert property (frame_valid_o && seen_reg |->
    frame_data_o[15] != $past(frame_data_o[15])) else $error("untoggled frame taken");
  a_watchdog_expiry: assert property (idle_reg ==
    (watchdog_period_select_i ? WD_LONG : WD_SHORT) + 8 |-> fail_mode_o)
    else $error("watchdog missed");
  a_switch_ch6: assert property (s_frame_taken |=> fail_mode_o ||
    external_switch_control_o == $past(frame_data_o[5])) else $error("switch not ch6");
  a_normal_pwm: assert property (s_normal_run |->
    channel_out_o == $past(pwm_channel_i)) else $error("channel not pwm");
  a_clock_fail_hold: assert property ($fell(clock_fail_o) |->
    $past(quick_status1_read_i)) else $error("clock fail cleared unread");
endmodule // supervisor_checker

bind spi_link_fail_supervisor supervisor_checker #(
  .CH_N(CH_N), .WD_SHORT(WD_SHORT), .WD_LONG(WD_LONG)
) chk (
  .clk_i(clk_i), .srst_i(srst_i), .fail_mode_i(fail_mode_i), .sleep_i(sleep_i),
  .watchdog_period_select_i(watchdog_period_select_i), .pwm_channel_i(pwm_channel_i),
  .quick_status1_read_i(quick_status1_read_i), .device_status7_o(device_status7_o),
  .spi_failure_flag_o(spi_failure_flag_o), .fail_mode_o(fail_mode_o),
  .clock_fail_o(clock_fail_o), .channel_out_o(channel_out_o),
  .external_switch_control_o(external_switch_control_o),
  .frame_data_o(frame_data_o), .frame_valid_o(frame_valid_o)
);

// ===== tb/host_link_model.sv
/*
  Host side of the serial link: sends frames MSB first at 80 ns.
  Assumes the caller supplies the toggle bit and the bit count.
*/
`timescale 1ns/100ps
module host_link_model (
  // Serial link pins
  output reg sclk_o,
  output reg cs_n_o,
  output reg sdi_o
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  localparam integer HALF_NS = 40;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Clock stands still outside frames; bit count is the caller's
  task send(input [31:0] word, input integer nbits);
    integer i;
    begin
      #7;
      cs_n_o = 1'b0;
      for (i = nbits - 1; i >= 0; i = i - 1) begin
        sdi_o = word[i];
        #HALF_NS;
        sclk_o = 1'b1;
        #HALF_NS;
        sclk_o = 1'b0;
      end
      #HALF_NS;
      cs_n_o = 1'b1;
      // Released line shows the inverse, not a stale bit
      sdi_o = ~sdi_o;
      #(4 * HALF_NS);
    end
  endtask
endmodule // host_link_model

// ===== tb/tb.sv
/*
  Testbench for the link fail supervisor.
  Assumes the bound checker and the host link model beside it.
*/
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  localparam integer WD_S = 2000;
  localparam integer WD_L = 8000;
  reg         clk_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         rst_n = 1'b0;
  reg         ext_clk = 1'b0;
  reg         fail_pin = 1'b0;
  reg  [3:0]  direct = 4'h0;
  reg         sel = 1'b0;
  reg         sleep = 1'b0;
  reg         qs = 1'b0;
  reg  [3:0]  pwm = 4'h6;
  reg  [3:0]  ctrl = 4'h9;
  reg         tog = 1'b1;
  reg  [15:0] nvalid = 16'h0;
  integer     ext_half = 500;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     i;
  wire        sclk, cs_n, sdi, flag, fail, clkf, ext_sw, fvalid;
  wire [15:0] stat7, fdata;
  wire [3:0]  chan;
  always #5 clk_i = ~clk_i;
  always begin
    repeat (ext_half) @(posedge clk_i);
    ext_clk <= ~ext_clk;
  end
  always @(posedge clk_i) if (fvalid === 1'b1) nvalid <= nvalid + 16'h1;
  host_link_model HOST (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  spi_link_fail_supervisor #(.WD_SHORT(WD_S), .WD_LONG(WD_L), .CLK_LOW_CYC(5000)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .fail_mode_i(fail_pin), .direct_channel_inputs_i(direct),
    .reset_input_n_i(rst_n), .ext_clock_i(ext_clk), .watchdog_period_select_i(sel),
    .sleep_i(sleep), .channel_control_signal_i(ctrl), .pwm_channel_i(pwm),
    .quick_status1_read_i(qs), .device_status7_o(stat7), .spi_failure_flag_o(flag),
    .fail_mode_o(fail), .clock_fail_o(clkf), .channel_out_o(chan),
    .external_switch_control_o(ext_sw), .frame_data_o(fdata), .frame_valid_o(fvalid));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input [95:0] what, input [15:0] exp, input [15:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Toggle bit inverted on every frame the host means to be good
  task good(input ch6, input integer n);
    reg [15:0] w;
    reg [15:0] v;
    begin
      w = {tog, 9'h0, ch6, 5'h0};
      v = nvalid;
      HOST.send({16'hffff, w}, n);
      tog = ~tog;
      @(posedge clk_i);
      check("valid", v + 16'h1, nvalid);
      check("data", w, fdata);
    end
  endtask
  task qs_read;
    begin
      qs <= 1'b1;
      @(posedge clk_i);
      qs <= 1'b0;
      tick(3);
    end
  endtask
  task wrap_up;
    begin
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(4);
    srst_i <= 1'b0;
    rst_n <= 1'b1;
    tick(4);
    check("chan", 4'h6, chan);
    good(1'b1, 16);
    check("switch", 1'b1, ext_sw);
    sleep <= 1'b1;
    tick(3);
    check("switch", 1'b0, ext_sw);
    sleep <= 1'b0;
    good(1'b0, 16);
    HOST.send(32'h0, 16);
    tick(1);
    check("fail", 1'b1, fail);
    check("status7", 16'h0001, stat7);
    HOST.send(32'h0fff, 12);
    tick(1);
    check("flag", 1'b1, flag);
    good(1'b1, 16);
    tick(2);
    check("flag", 1'b0, flag);
    check("switch", 1'b1, ext_sw);
    HOST.send(32'h0fff, 12);
    tick(1);
    check("fail", 1'b1, fail);
    good(1'b0, 32);
    tick(2);
    check("fail", 1'b0, fail);
    tick(WD_S - 200);
    check("fail", 1'b0, fail);
    tick(400);
    check("fail", 1'b1, fail);
    good(1'b1, 16);
    sel <= 1'b1;
    tick(WD_L - 200);
    check("fail", 1'b0, fail);
    tick(400);
    check("flag", 1'b1, flag);
    good(1'b0, 16);
    ext_half <= 50;
    tick(6000);
    check("clkfail", 1'b1, clkf);
    check("chan", 4'h9, chan);
    rst_n <= 1'b0;
    tick(500);
    rst_n <= 1'b1;
    tick(4);
    qs_read;
    check("clkfail", 1'b1, clkf);
    good(1'b1, 16);
    ext_half <= 500;
    tick(1500);
    check("clkfail", 1'b1, clkf);
    qs_read;
    check("clkfail", 1'b0, clkf);
    check("chan", 4'h6, chan);
    fail_pin <= 1'b1;
    tick(3);
    check("status7", 16'h0002, stat7);
    good(1'b0, 16);
    tick(4800);
    fail_pin <= 1'b0;
    tick(3);
    check("fail", 1'b0, fail);
    good(1'b1, 16);
    fail_pin <= 1'b1;
    direct <= 4'h5;
    for (i = 0; i < 3; i = i + 1) begin
      tick(4700);
      good(i[0], 16);
    end
    tick(4400);
    check("fail", 1'b0, fail);
    tick(1300);
    check("fail", 1'b1, fail);
    check("chan", 4'h5, chan);
    fail_pin <= 1'b0;
    direct <= 4'h0;
    tick(19000);
    check("chan", 4'h5, chan);
    tick(1300);
    check("chan", 4'h0, chan);
    good(1'b0, 16);
    tick(4);
    check("fail", 1'b0, fail);
    check("flag", 1'b0, flag);
    wrap_up;
  end
endmodule // tb
